// ==== hw/adc_conversion_sequencer.v ====
// Purpose: request arbitration, bit-trial sequencing and result storage
//          for two successive-approximation converter units
// Assumes: comparator inputs settle within one step; all inputs synchronous
// Notes:   unit b converts only in synchronized mode, alongside unit a
`timescale 1ns/1ns
`include "adc_seq_map.vh"

module adc_conversion_sequencer #(
   parameter ACC_W = 4
)(
   // clock and reset
   input  wire         core_clk_i,
   input  wire         rst_i,
   // timing and mode
   input  wire [7:0]   sample_cycles_i,
   input  wire [7:0]   step_cycles_i,
   input  wire         low_res_i,
   input  wire         sync_mode_i,
   input  wire [3:0]   sync_ch_i,
   input  wire         auto_pd_i,
   input  wire         ext_mux_en_i,
   // data reduction and result storage
   input  wire [1:0]   red_mode_i,
   input  wire [9:0]   lim_lo_i,
   input  wire [9:0]   lim_hi_i,
   input  wire [ACC_W-1:0] acc_num_i,
   input  wire         chain_i,
   input  wire [7:0]   wfr_en_i,
   // test features
   input  wire [8:0]   bw_en_i,
   input  wire         mux_test_i,
   // pins and digital inputs
   input  wire [8:0]   pin_i,
   input  wire [8:0]   dig_dis_i,
   output wire [8:0]   dig_in_o,
   // parallel source
   input  wire [8:0]   par_mask_i,
   input  wire         par_sw_trig_i,
   input  wire         par_ext_trig_i,
   input  wire         par_trig_sel_i,
   input  wire [1:0]   par_prio_i,
   // queued source
   input  wire         q_wr_i,
   input  wire [3:0]   q_ch_i,
   output wire         q_full_o,
   input  wire         q_sw_trig_i,
   input  wire         q_ext_trig_i,
   input  wire         q_trig_sel_i,
   input  wire [1:0]   q_prio_i,
   // inserted conversion
   input  wire         ins_req_i,
   input  wire [3:0]   ins_ch_i,
   input  wire [1:0]   ins_prio_i,
   // analog front end
   input  wire [1:0]   comp_i,
   output reg  [19:0]  dac_o,
   output wire [1:0]   sample_o,
   output reg  [3:0]   ch_sel_a_o,
   output reg  [3:0]   ch_sel_b_o,
   output reg  [2:0]   ext_mux_o,
   output wire [1:0]   pd_o,
   output wire         bw_pre_o,
   output wire         mux_test_o,
   output wire         stall_o,
   // events
   output reg  [1:0]   conv_done_o,
   output reg  [1:0]   limit_evt_o,
   // result read port, through two-entry buffer
   input  wire         rd_req_i,
   input  wire         rd_unit_i,
   input  wire [2:0]   rd_idx_i,
   output wire         rd_ready_o,
   output wire         res_valid_o,
   input  wire         res_ready_i,
   output wire [`ADC_RES_W-1:0] res_data_o,
   output wire [3:0]   res_ch_o,
   output wire         res_fresh_o,
   output wire         res_unit_o
);

   localparam BW = `ADC_RES_W + 6;  // data, channel, fresh, unit

   reg  [4:0]  state_q;
   reg  [7:0]  cnt_q;
   reg  [3:0]  bit_q;
   reg  [1:0]  src_q;
   reg  [8:0]  par_act_q;
   reg  [3:0]  q_mem [0:`ADC_Q_DEPTH-1];
   reg  [1:0]  q_wp_q;
   reg  [1:0]  q_rp_q;
   reg  [2:0]  q_cnt_q;
   reg         q_run_q;
   reg         ins_pend_q;
   reg  [3:0]  ins_ch_q;
   reg  [BW-1:0] buf_q [0:1];
   reg  [1:0]  buf_cnt_q;
   wire [1:0]  blk_w;
   wire [2*BW-1:0] rword_w;
   wire [1:0]  lim_w;
   wire [3:0]  lsb_w = low_res_i ? `ADC_LSB_LOW : `ADC_LSB_FULL;
   wire        step_end = state_q[3] && (cnt_q == 8'h00);
   wire        storing  = state_q[4];

   // digital readback, gated per pin; disabled pins read zero
   assign dig_in_o = pin_i & ~dig_dis_i;

   // trigger selection per source
   wire par_go = par_trig_sel_i ? par_ext_trig_i : par_sw_trig_i;
   wire q_go   = q_trig_sel_i ? q_ext_trig_i : q_sw_trig_i;

   // lowest active channel of the parallel source is next
   reg [3:0] par_ch;
   integer   k;
   always @*
   begin
      par_ch = 4'h0;
      for (k = `ADC_NUM_CH - 1; k >= 0; k = k - 1)
         if (par_act_q[k])
            par_ch = k[3:0];
   end

   // priority arbiter; ties go insert, then parallel, then queue
   wire       par_req = |par_act_q;
   wire       q_req   = q_run_q && (q_cnt_q != 3'h0);
   reg  [1:0] win_src;
   reg  [3:0] win_ch;
   reg        win_any;
   always @*
   begin
      win_any = ins_pend_q | par_req | q_req;
      win_src = `SRC_QUE;
      win_ch  = q_mem[q_rp_q];
      if (par_req && (!q_req || par_prio_i >= q_prio_i))
      begin
         win_src = `SRC_PAR;
         win_ch  = par_ch;
      end
      if (ins_pend_q && ((!par_req || ins_prio_i >= par_prio_i) &&
                         (!q_req || ins_prio_i >= q_prio_i)))
      begin
         win_src = `SRC_INS;
         win_ch  = ins_ch_q;
      end
   end

   // hold off while a protected target is unread, on either active unit
   wire tgt_blk = blk_w[0] | (sync_mode_i & blk_w[1]);
   wire grant   = state_q[0] && win_any && !tgt_blk;
   assign stall_o = state_q[0] && win_any && tgt_blk;

   // sequencer
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q    <= `ST_IDLE;
         cnt_q      <= 8'h00;
         bit_q      <= 4'h0;
         src_q      <= 2'h0;
         ch_sel_a_o <= 4'h0;
         ch_sel_b_o <= 4'h0;
         ext_mux_o  <= 3'h0;
      end
      else
      begin
         case (state_q)
            `ST_IDLE:
               if (grant)
               begin
                  src_q      <= win_src;
                  ch_sel_a_o <= win_ch;
                  ch_sel_b_o <= sync_ch_i;
                  cnt_q      <= sample_cycles_i;
                  state_q    <= bw_en_i[win_ch] ? `ST_BWPRE : `ST_SAMPLE;
               end
            `ST_BWPRE:
               if (cnt_q == 8'h00)
               begin
                  cnt_q   <= sample_cycles_i;
                  state_q <= `ST_SAMPLE;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            `ST_SAMPLE:
               if (cnt_q == 8'h00)
               begin
                  cnt_q   <= step_cycles_i;
                  bit_q   <= `ADC_MSB_IDX;
                  state_q <= `ST_CONV;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            `ST_CONV:
               if (cnt_q != 8'h00)
                  cnt_q <= cnt_q - 8'h01;
               else if (bit_q == lsb_w)
                  state_q <= `ST_STORE;
               else
               begin
                  bit_q <= bit_q - 4'h1;
                  cnt_q <= step_cycles_i;
               end
            `ST_STORE:
            begin
               // next external mux input once this one is done
               if (ext_mux_en_i)
                  ext_mux_o <= ext_mux_o + 3'h1;
               state_q <= `ST_IDLE;
            end
            default:
               state_q <= `ST_IDLE;
         endcase
      end
   end

   // analog control strobes; unit b only joins in synchronized mode
   assign sample_o   = {sync_mode_i & state_q[2], state_q[2]};
   assign bw_pre_o   = state_q[1];
   assign mux_test_o = mux_test_i & state_q[2];
   assign pd_o = {2{auto_pd_i & state_q[0]}} | {~sync_mode_i, 1'b0};

   // request bookkeeping; a source entry is consumed only when its conversion
   // completes, so an inserted conversion leaves the others untouched
   wire done_par = storing && (src_q == `SRC_PAR);
   wire done_q   = storing && (src_q == `SRC_QUE);
   wire done_ins = storing && (src_q == `SRC_INS);
   wire q_push   = q_wr_i && (q_cnt_q != `ADC_Q_FULL);
   assign q_full_o = (q_cnt_q == `ADC_Q_FULL);
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         par_act_q  <= 9'h000;
         q_wp_q     <= 2'h0;
         q_rp_q     <= 2'h0;
         q_cnt_q    <= 3'h0;
         q_run_q    <= 1'b0;
         ins_pend_q <= 1'b0;
         ins_ch_q   <= 4'h0;
      end
      else
      begin
         // trigger sets win over completion clears
         par_act_q <= (par_act_q & ~(done_par ? (9'h001 << ch_sel_a_o) : 9'h000)) |
                      (par_go ? par_mask_i : 9'h000);
         if (q_push)
         begin
            q_mem[q_wp_q] <= q_ch_i;
            q_wp_q        <= q_wp_q + 2'h1;
         end
         if (done_q)
            q_rp_q <= q_rp_q + 2'h1;
         q_cnt_q <= q_cnt_q + {2'h0, q_push} - {2'h0, done_q};
         if (q_go)
            q_run_q <= 1'b1;
         else if (q_cnt_q == 3'h0)
            q_run_q <= 1'b0;
         if (ins_req_i)
         begin
            ins_pend_q <= 1'b1;
            ins_ch_q   <= ins_ch_i;
         end
         else if (done_ins)
            ins_pend_q <= 1'b0;
      end
   end

   // read acceptance into the output buffer
   wire buf_in_rdy = (buf_cnt_q != 2'h2);
   wire rd_take    = rd_req_i && buf_in_rdy;
   assign rd_ready_o = buf_in_rdy;

   // per-unit bit trial, reduction and result registers
   genvar u;
   generate
      for (u = 0; u < 2; u = u + 1)
      begin : g_unit
         reg  [9:0]             sar_q;
         reg  [`ADC_RES_W+3:0]  mem [0:`ADC_NUM_RES-1];
         reg  [7:0]             val_q;
         reg  [2:0]             wp_q;
         reg  [2:0]             rp_q;
         reg  [`ADC_RES_W-1:0]  acc_q;
         reg  [ACC_W-1:0]       acc_n_q;
         wire                   act = (u == 0) | sync_mode_i;
         wire [3:0]             ch  = (u == 0) ? ch_sel_a_o : ch_sel_b_o;
         wire [2:0]             tgt = chain_i ? wp_q : ch[2:0];
         // guard looks at the register the next grant would write, not the last one
         wire [3:0]             nch = (u == 0) ? win_ch : sync_ch_i;
         wire [2:0]             nxt = chain_i ? wp_q : nch[2:0];
         wire [9:0]             res = low_res_i ? {2'b00, sar_q[9:2]} : sar_q;
         wire                   outl = (res < lim_lo_i) || (res > lim_hi_i);
         wire                   acc_last = (acc_n_q == acc_num_i);
         wire [`ADC_RES_W-1:0]  acc_sum = acc_q + {3'h0, res};
         wire                   keep = (red_mode_i == `RED_LIMIT) ? outl :
                                       (red_mode_i == `RED_ACCUM) ? acc_last : 1'b1;
         wire                   wr = storing && act && keep;
         wire                   rd = rd_take && (rd_unit_i == u);
         wire [2:0]             ri = chain_i ? rp_q : rd_idx_i;
         wire [`ADC_RES_W-1:0]  wdat = (red_mode_i == `RED_ACCUM) ? acc_sum
                                                                 : {3'h0, res};

         assign blk_w[u] = val_q[nxt] & wfr_en_i[nxt];
         assign lim_w[u] = storing && act && (red_mode_i == `RED_LIMIT) && outl;
         assign rword_w[u*BW +: BW] = {mem[ri], val_q[ri], (u == 1)};

         always @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               sar_q   <= 10'h000;
               val_q   <= 8'h00;
               wp_q    <= 3'h0;
               rp_q    <= 3'h0;
               acc_q   <= {`ADC_RES_W{1'b0}};
               acc_n_q <= {ACC_W{1'b0}};
            end
            else
            begin
               // keep or drop each trial bit on the comparator answer
               if (state_q[2])
                  sar_q <= `ADC_TRIAL_MSB;
               else if (step_end && act)
               begin
                  sar_q[bit_q] <= comp_i[u];
                  if (bit_q != lsb_w)
                     sar_q[bit_q - 4'h1] <= 1'b1;
               end
               // accumulation restarts after each stored sum
               if (storing && act && (red_mode_i == `RED_ACCUM))
               begin
                  acc_q   <= acc_last ? {`ADC_RES_W{1'b0}} : acc_sum;
                  acc_n_q <= acc_last ? {ACC_W{1'b0}} : acc_n_q + 1'b1;
               end
               if (wr)
               begin
                  mem[tgt] <= {wdat, ch};
                  if (chain_i)
                     wp_q <= wp_q + 3'h1;
               end
               // a chained read, or an overwrite of the unread oldest word, moves the
               // read pointer; both in one cycle still move it by one
               if (chain_i && ((rd && val_q[ri]) || (wr && val_q[tgt] && rp_q == wp_q)))
                  rp_q <= rp_q + 3'h1;
               // a fresh store wins over a read clear of the same register
               val_q <= (val_q & ~((rd ? 8'h01 : 8'h00) << ri)) |
                        ((wr ? 8'h01 : 8'h00) << tgt);
            end
         end
      end
   endgenerate

   // trial codes to the converter arrays, events to the outside
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         dac_o       <= 20'h00000;
         conv_done_o <= 2'h0;
         limit_evt_o <= 2'h0;
      end
      else
      begin
         dac_o       <= {g_unit[1].sar_q, g_unit[0].sar_q};
         conv_done_o <= {storing & sync_mode_i, storing};
         limit_evt_o <= lim_w;
      end
   end

   // two-entry buffer: a stalled reader or transfer controller loses nothing
   wire [BW-1:0] rsel = rword_w[rd_unit_i*BW +: BW];
   wire          pop  = res_ready_i && (buf_cnt_q != 2'h0);
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         buf_cnt_q <= 2'h0;
         buf_q[0]  <= {BW{1'b0}};
         buf_q[1]  <= {BW{1'b0}};
      end
      else
      begin
         if (pop)
            buf_q[0] <= buf_q[1];
         if (rd_take)
         begin
            if (buf_cnt_q == 2'h0 || (buf_cnt_q == 2'h1 && pop))
               buf_q[0] <= rsel;
            else
               buf_q[1] <= rsel;   // one word held and staying: new one goes behind it
         end
         buf_cnt_q <= buf_cnt_q + {1'b0, rd_take} - {1'b0, pop};
      end
   end

   assign res_valid_o = (buf_cnt_q != 2'h0);
   assign res_data_o  = buf_q[0][BW-1 -: `ADC_RES_W];
   assign res_ch_o    = buf_q[0][5:2];
   assign res_fresh_o = buf_q[0][1];
   assign res_unit_o  = buf_q[0][0];

endmodule

// ==== hw/adc_seq_map.vh ====
// Purpose: shared constants of the conversion sequencer
// Assumes: included by its bare name
// Notes:   widths, one-hot states, data reduction modes
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// converter geometry
`define ADC_NUM_CH      9
`define ADC_RES_BITS    10
`define ADC_MSB_IDX     4'h9
`define ADC_LSB_FULL    4'h0
`define ADC_LSB_LOW     4'h2
`define ADC_TRIAL_MSB   10'h200
`define ADC_NUM_RES     8
`define ADC_RES_W       13
`define ADC_Q_DEPTH     4
`define ADC_Q_FULL      3'h4

// sequencer states, one-hot
`define ST_IDLE         5'h01
`define ST_BWPRE        5'h02
`define ST_SAMPLE       5'h04
`define ST_CONV         5'h08
`define ST_STORE        5'h10

// data reduction modes
`define RED_NONE        2'h0
`define RED_LIMIT       2'h1
`define RED_ACCUM       2'h2

// request source codes
`define SRC_INS         2'h0
`define SRC_PAR         2'h1
`define SRC_QUE         2'h2

`endif

// ==== testbench/adc_seq_chk.sv ====
// Purpose: port-level checks of the conversion sequencer
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   bound to the sequencer; unit b is only checked outside synchronized mode
`timescale 1ns/1ns
module adc_seq_chk (
   // clock and reset
   input wire         core_clk_i,
   input wire         rst_i,
   // controls
   input wire [7:0]   sample_cycles_i,
   input wire         auto_pd_i,
   input wire         sync_mode_i,
   input wire [1:0]   red_mode_i,
   input wire         mux_test_i,
   input wire [8:0]   pin_i,
   input wire [8:0]   dig_dis_i,
   input wire         rd_req_i,
   input wire         res_ready_i,
   // outputs under watch
   input wire [8:0]   dig_in_o,
   input wire [19:0]  dac_o,
   input wire [1:0]   sample_o,
   input wire [3:0]   ch_sel_a_o,
   input wire [1:0]   pd_o,
   input wire         mux_test_o,
   input wire         stall_o,
   input wire [1:0]   conv_done_o,
   input wire [1:0]   limit_evt_o,
   input wire         rd_ready_o,
   input wire         res_valid_o,
   input wire [12:0]  res_data_o
);
   reg [8:0] scnt_q;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // length of the sample phase; one bit wider than the field so it never wraps
   always @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         scnt_q <= 9'h000;
      else
         scnt_q <= sample_o[0] ? scnt_q + 9'h001 : 9'h000;

   chk_dig_gate: assert property (
      dig_in_o == (pin_i & ~dig_dis_i)) else $error("digital input gate wrong");
   chk_sample_len: assert property (
      $fell(sample_o[0]) |-> scnt_q == {1'b0, sample_cycles_i} + 9'h001)
      else $error("sample phase length wrong");
   chk_pd_busy: assert property (
      (sample_o[0] || !auto_pd_i) |-> !pd_o[0]) else $error("unit a powered down");
   chk_b_idle: assert property (
      !sync_mode_i |-> pd_o[1] && !sample_o[1]) else $error("unit b active unsynced");
   chk_done_pulse: assert property (
      conv_done_o[0] |=> !conv_done_o[0]) else $error("done not a pulse");
   chk_limit_evt: assert property (
      limit_evt_o[0] |-> conv_done_o[0] && red_mode_i == 2'h1)
      else $error("limit event out of place");
   chk_rd_answer: assert property (
      rd_req_i && rd_ready_o && !res_valid_o |=> res_valid_o) else $error("read not answered");
   chk_res_hold: assert property (
      res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
      else $error("result dropped while stalled");
   chk_mux_test: assert property (
      sample_o[0] |-> mux_test_o == mux_test_i) else $error("mux test level wrong");
   chk_sel_hold: assert property (
      sample_o[0] && $past(sample_o[0]) |-> $stable(ch_sel_a_o))
      else $error("channel changed in sampling");
   chk_first_trial: assert property (
      $fell(sample_o[0]) |-> ##[0:3] dac_o[9:0] == 10'h200) else $error("msb not tried first");

   // main scenarios reached
   cover property (conv_done_o[0]);
   cover property (limit_evt_o[0]);
   cover property ($rose(stall_o));
   cover property (!rd_ready_o);
   cover property (sample_o[1]);
endmodule

bind adc_conversion_sequencer adc_seq_chk chk_u (.*);

// ==== testbench/analog_src_model.sv ====
// Purpose: analog sources and comparators in front of both units
// Assumes: ten-bit level per channel set by the bench
// Notes:   answers at once; the step length covers the trial code lag
`timescale 1ns/1ns
module analog_src_model (
   // trial codes and selection
   input  wire [19:0] dac_i,
   input  wire [3:0]  sel_a_i,
   input  wire [3:0]  sel_b_i,
   // channel levels and answers
   input  wire [89:0] lvl_i,
   output wire [1:0]  comp_o
);
   // high while the selected input is at or above the trial code
   assign comp_o[0] = lvl_i[sel_a_i*10 +: 10] >= dac_i[9:0];
   assign comp_o[1] = lvl_i[sel_b_i*10 +: 10] >= dac_i[19:10];
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench of the conversion sequencer
// Assumes: inputs change at the falling edge; fixed seed
// Notes:   unit b converts only in the closing synchronized scenario
`timescale 1ns/1ns
module testbench;
   logic        core_clk_i = 0, rst_i = 1;
   logic [7:0]  sample_cycles_i = 8'h03, step_cycles_i = 8'h01, wfr_en_i = 8'h00;
   logic        low_res_i = 0, sync_mode_i = 0, auto_pd_i = 1, ext_mux_en_i = 1;
   logic        chain_i = 0, mux_test_i = 0, par_sw_trig_i = 0, par_ext_trig_i = 0;
   logic        par_trig_sel_i = 1, q_wr_i = 0, q_sw_trig_i = 0, q_ext_trig_i = 0;
   logic        q_trig_sel_i = 0, ins_req_i = 0, rd_req_i = 0, rd_unit_i = 0;
   logic        res_ready_i = 0, q_full_o, rd_ready_o, res_valid_o, stall_o;
   logic        res_fresh_o, res_unit_o, bw_pre_o, mux_test_o;
   logic [3:0]  sync_ch_i = 4'h8, q_ch_i = 4'h0, ins_ch_i = 4'h0, acc_num_i = 4'h0;
   logic [3:0]  ch_sel_a_o, ch_sel_b_o, res_ch_o, c;
   logic [1:0]  red_mode_i = 2'h0, par_prio_i = 2'h1, q_prio_i = 2'h0, ins_prio_i = 2'h3;
   logic [1:0]  comp_i, sample_o, pd_o, conv_done_o, limit_evt_o;
   logic [9:0]  lim_lo_i = 10'h064, lim_hi_i = 10'h0c8, v, v2, lv[9];
   logic [8:0]  bw_en_i = 9'h000, pin_i = 9'h000, dig_dis_i = 9'h000, par_mask_i = 9'h000;
   logic [8:0]  dig_in_o;
   logic [2:0]  rd_idx_i = 3'h0, ext_mux_o;
   logic [19:0] dac_o;
   logic [12:0] res_data_o;
   logic [89:0] lvl = 90'h0;
   logic [3:0]  done_q[$];
   int          seed = 67335, errors = 0, n_tests = 0, lim_n = 0, bw_n = 0, n_conv = 0;
   int          pch[4] = '{1, 3, 4, 6};
   int          qch[4] = '{2, 0, 5, 7};

   adc_conversion_sequencer #(.ACC_W(4)) dut_u (.*);
   analog_src_model src_u (.dac_i(dac_o), .sel_a_i(ch_sel_a_o), .sel_b_i(ch_sel_b_o),
                           .lvl_i(lvl), .comp_o(comp_i));

   // 100 MHz clock
   always #5 core_clk_i = ~core_clk_i;

   // record converted channels in completion order
   always @(posedge core_clk_i)
   begin
      if (conv_done_o[0] === 1'b1) done_q.push_back(ch_sel_a_o);
      if (conv_done_o[0] === 1'b1) n_conv++;
      if (limit_evt_o[0] === 1'b1) lim_n++;
      if (bw_pre_o === 1'b1) bw_n++;
   end

   task chk(input logic [12:0] seen, input logic [12:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
   endtask

   function logic [12:0] expv(input logic [9:0] x, input logic lo);
      return lo ? {5'h00, x[9:2]} : {3'h0, x};
   endfunction

   task setlv(input logic [3:0] ch, output logic [9:0] x);
      x = 10'($random(seed));
      lvl[ch*10 +: 10] = x;
      lv[ch] = x;
   endtask

   task wait_n(input int n);
      int k;
      k = 0;
      while (done_q.size() < n && k < 3000)
      begin
         @(negedge core_clk_i);
         k++;
      end
      if (k >= 3000) chk(13'h1fff, 13'h0);
   endtask

   task ins(input logic [3:0] ch);
      @(negedge core_clk_i);
      ins_ch_i = ch;
      ins_req_i = 1;
      @(negedge core_clk_i);
      ins_req_i = 0;
   endtask

   // request held until a rising edge sees ready high
   task rd_issue(input logic [2:0] i);
      int k;
      k = 0;
      @(negedge core_clk_i);
      rd_idx_i = i;
      rd_req_i = 1;
      while (rd_ready_o !== 1'b1 && k < 50)
      begin
         @(negedge core_clk_i);
         k++;
      end
      if (k >= 50) chk(13'h1fff, 13'h0);
      @(negedge core_clk_i);
      rd_req_i = 0;
   endtask

   task rd_take(input logic [3:0] ec, input logic [12:0] ed);
      int k;
      k = 0;
      while (res_valid_o !== 1'b1 && k < 50)
      begin
         @(negedge core_clk_i);
         k++;
      end
      if (k >= 50) chk(13'h1fff, 13'h0);
      chk(res_data_o, ed);
      chk({7'h0, res_unit_o, res_fresh_o, res_ch_o}, {7'h0, rd_unit_i, 1'b1, ec});
      res_ready_i = 1;
      @(negedge core_clk_i);
      res_ready_i = 0;
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge core_clk_i);
      @(negedge core_clk_i) rst_i = 0;
      chk({9'h0, rd_ready_o, res_valid_o, q_full_o, stall_o}, 13'h008);
      $display("reset test done");
      repeat (20)
      begin
         @(negedge core_clk_i);
         {pin_i, dig_dis_i, mux_test_i} = 19'($random(seed));
         #1 chk({4'h0, dig_in_o}, {4'h0, pin_i & ~dig_dis_i});
      end
      $display("digital input test done");
      for (int i = 0; i < 8; i++)
      begin
         c = 4'({$random(seed)} % 9);
         low_res_i = i[0];
         bw_en_i = 9'($random(seed));
         setlv(c, v);
         done_q.delete();
         bw_n = 0;
         ins(c);
         wait_n(1);
         chk(13'(bw_n), bw_en_i[c] ? {5'h0, sample_cycles_i} + 13'h1 : 13'h0);
         rd_issue(c[2:0]);
         rd_take(c, expv(v, low_res_i));
      end
      $display("insert test done");
      {low_res_i, bw_en_i, par_mask_i} = {1'b0, 9'h000, 9'h052};
      foreach (pch[i]) setlv(4'(pch[i]), v);
      done_q.delete();
      // wrong trigger source must be ignored
      @(negedge core_clk_i) par_sw_trig_i = 1;
      @(negedge core_clk_i) par_sw_trig_i = 0;
      repeat (60) @(negedge core_clk_i);
      chk(13'(done_q.size()), 13'h0);
      @(negedge core_clk_i) par_ext_trig_i = 1;
      @(negedge core_clk_i) par_ext_trig_i = 0;
      repeat (5) @(negedge core_clk_i);
      ins(4'h3);
      wait_n(4);
      par_mask_i = 9'h000;
      foreach (pch[i]) chk({9'h0, done_q[i]}, 13'(pch[i]));
      foreach (pch[i])
      begin
         rd_issue(3'(pch[i]));
         rd_take(4'(pch[i]), expv(lv[pch[i]], 1'b0));
      end
      $display("parallel test done");
      chain_i = 1;
      done_q.delete();
      foreach (qch[i]) setlv(4'(qch[i]), v);
      for (int i = 0; i < 5; i++)
      begin
         @(negedge core_clk_i);
         q_wr_i = 1;
         q_ch_i = (i < 4) ? 4'(qch[i]) : 4'h8;
      end
      @(negedge core_clk_i) q_wr_i = 0;
      chk({12'h0, q_full_o}, 13'h1);
      @(negedge core_clk_i) q_sw_trig_i = 1;
      @(negedge core_clk_i) q_sw_trig_i = 0;
      wait_n(4);
      repeat (60) @(negedge core_clk_i);
      chk(13'(done_q.size()), 13'h4);
      foreach (qch[i]) chk({9'h0, done_q[i]}, 13'(qch[i]));
      // fill the two-entry buffer while the reader stalls
      rd_issue(3'h7);
      rd_issue(3'h7);
      chk({12'h0, rd_ready_o}, 13'h0);
      rd_take(4'h2, expv(lv[2], 1'b0));
      rd_take(4'h0, expv(lv[0], 1'b0));
      for (int i = 2; i < 4; i++)
      begin
         rd_issue(3'h1);
         rd_take(4'(qch[i]), expv(lv[qch[i]], 1'b0));
      end
      $display("queue and chain test done");
      {chain_i, wfr_en_i} = {1'b0, 8'hff};
      done_q.delete();
      setlv(4'h3, v);
      ins(4'h3);
      wait_n(1);
      setlv(4'h3, v2);
      ins(4'h3);
      repeat (10) @(negedge core_clk_i);
      chk({12'h0, stall_o}, 13'h1);
      rd_issue(3'h3);
      rd_take(4'h3, expv(v, 1'b0));
      wait_n(2);
      rd_issue(3'h3);
      rd_take(4'h3, expv(v2, 1'b0));
      $display("wait for read test done");
      {wfr_en_i, red_mode_i} = {8'h00, 2'h1};
      lvl[60 +: 10] = 10'h300;
      done_q.delete();
      ins(4'h6);
      wait_n(1);
      lvl[60 +: 10] = 10'h080;
      ins(4'h6);
      wait_n(2);
      repeat (2) @(negedge core_clk_i);
      chk(13'(lim_n), 13'h1);
      rd_issue(3'h6);
      rd_take(4'h6, 13'h0300);
      $display("limit test done");
      {red_mode_i, acc_num_i} = {2'h2, 4'h1};
      done_q.delete();
      ins(4'h6);
      wait_n(1);
      ins(4'h6);
      wait_n(2);
      rd_issue(3'h6);
      rd_take(4'h6, 13'h0100);
      $display("accumulate test done");
      {red_mode_i, sync_mode_i} = {2'h0, 1'b1};
      setlv(4'h2, v);
      setlv(4'h8, v2);
      done_q.delete();
      ins(4'h2);
      wait_n(1);
      rd_issue(3'h2);
      rd_take(4'h2, expv(v, 1'b0));
      rd_unit_i = 1;
      rd_issue(3'h0);
      rd_take(4'h8, expv(v2, 1'b0));
      rd_unit_i = 0;
      chk({10'h0, ext_mux_o}, 13'(n_conv % 8));
      chk({9'h0, ch_sel_b_o}, {9'h0, sync_ch_i});
      $display("sync test done");
      close_out;
   end

   // watchdog well beyond the expected run of about a thousand cycles
   initial
   begin
      #300000;
      errors++;
      $display("MISMATCH %0t watchdog expired", $time);
      close_out;
   end
endmodule
